// ===== rocc_ctrl.sv
/*
 crystal oscillator and clock output control with register port and interrupt.
 assumes the sequencer strobes and power state come from logic on clk; pins are async.
*/
// Summary of operation
// - crystal runs in OFF, ON, SLEEP when enabled
// - crystal enable loaded only by configuration load
// - backup keeps crystal only with both enables
// - host sets output enable in ON/SLEEP
// - output forced off in OFF state
// - drive bit 13: push-pull or open-drain
// - on-slot codes 1..5 enable in slot
// - sleep-slot codes 1..5 disable in slots 5..1
// - good bit only when enabled and verified
// - inhibit 0: RC clock until crystal ready
// - glitch-free switch from RC to crystal
// - inhibit 1: hold ON until crystal verified
// - inhibit 1 and failure: reset after 32 s
// - gpio oscillator output runs in OFF too
// - 2 MHz clock only with a power enable
// - output enable writes need unlocked key
// - inhibit at bit 15 of 4091h, default 0
`timescale 1ns/1ps
`default_nettype none
module rocc_ctrl
   import rocc_pkg::*;
#(
   parameter longint FAIL_CYCLES = ROCC_FAIL_CYCLES
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [15:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [15:0] rdata,
   input wire logic external_config_load,
   input wire logic cfg_crystal_enable,
   input wire logic cfg_crystal_backup_retain,
   input wire logic cfg_startup_inhibit,
   input wire rocc_pstate_e pstate,
   input wire rocc_seq_s seq,
   input wire logic on_request,
   output logic on_grant,
   input wire logic oscillator_input_pin,
   input wire logic xtal_verified,
   input wire logic xtal_failed,
   output logic crystal_run,
   output logic clock_output_pin,
   output logic clock_output_pin_oe,
   output logic gpio_osc_out,
   input wire logic external_power_enable_a,
   input wire logic external_power_enable_b,
   output logic ext_power_clk,
   output logic system_reset_req,
   output logic irq
);
   initial begin
      if (FAIL_CYCLES < 1) begin
         $error("rocc_ctrl: FAIL_CYCLES must be positive");
      end
   end
   // --------------------------------------------------------------
   // pin synchronisers
   // --------------------------------------------------------------
   logic xtal_s;
   logic verified_s;
   logic failed_s;
   rocc_sync #(.WIDTH(3)) u_sync (
      .clk(clk),
      .nrst(nrst),
      .din({oscillator_input_pin, xtal_verified, xtal_failed}),
      .dout({xtal_s, verified_s, failed_s})
   );
   // --------------------------------------------------------------
   // registers
   // --------------------------------------------------------------
   logic xtal_en_q;
   logic bkup_q;
   logic inhibit_q;
   logic out_en_q;
   logic drive_q;
   logic [2:0] on_slot_q;
   logic [2:0] slp_slot_q;
   logic unlocked_q;
   logic [ROCC_N_IRQ-1:0] irq_stat_q;
   logic [ROCC_N_IRQ-1:0] irq_mask_q;
   logic good_q;
   logic wr_ctl1;
   logic wr_ctl2;
   assign wr_ctl1 = wr && addr == ROCC_ADDR_CLKCTL1;
   assign wr_ctl2 = wr && addr == ROCC_ADDR_CLKCTL2;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         xtal_en_q <= 1'b0;
      end else if (external_config_load) begin
         xtal_en_q <= cfg_crystal_enable;
      end
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         inhibit_q <= ROCC_RST_INHIBIT;
         bkup_q <= ROCC_RST_BKUP;
      end else if (external_config_load) begin
         inhibit_q <= cfg_startup_inhibit;
         bkup_q <= cfg_crystal_backup_retain;
      end else if (wr_ctl2) begin
         inhibit_q <= wdata[ROCC_B_INHIBIT];
         bkup_q <= wdata[ROCC_B_BKUP];
      end
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         unlocked_q <= 1'b0;
      end else if (wr && addr == ROCC_ADDR_KEY) begin
         unlocked_q <= wdata == ROCC_KEY_UNLOCK;
      end
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         drive_q <= 1'b0;
         on_slot_q <= 3'h0;
         slp_slot_q <= 3'h0;
      end else if (wr_ctl1) begin
         drive_q <= wdata[ROCC_B_DRIVE];
         on_slot_q <= wdata[ROCC_B_ON_SLOT +: 3];
         slp_slot_q <= wdata[ROCC_B_SLP_SLOT +: 3];
      end
   end
   // --------------------------------------------------------------
   // output enable: host, slots, OFF state
   // --------------------------------------------------------------
   logic on_hit;
   logic slp_hit;
   assign on_hit = seq.on_seq && on_slot_q >= ROCC_SLOT_MIN && on_slot_q <= ROCC_SLOT_MAX
      && seq.slot == on_slot_q;
   assign slp_hit = seq.sleep_seq && slp_slot_q >= ROCC_SLOT_MIN
      && slp_slot_q <= ROCC_SLOT_MAX && seq.slot == ROCC_SLP_BASE - slp_slot_q;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         out_en_q <= 1'b0;
      end else if (pstate == ROCC_PS_OFF || pstate == ROCC_PS_BACKUP) begin
         out_en_q <= 1'b0;
      end else if (on_hit) begin
         out_en_q <= 1'b1;
      end else if (slp_hit) begin
         out_en_q <= 1'b0;
      end else if (wr_ctl1 && unlocked_q) begin
         out_en_q <= wdata[ROCC_B_OUT_EN];
      end
   end
   // --------------------------------------------------------------
   // oscillator run and good status
   // --------------------------------------------------------------
   // run per power state
   assign crystal_run = xtal_en_q && (pstate != ROCC_PS_BACKUP || bkup_q);
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         good_q <= 1'b0;
      end else begin
         good_q <= crystal_run && verified_s && !failed_s;
      end
   end
   assign on_grant = on_request && (!inhibit_q || good_q);
   logic [$clog2(FAIL_CYCLES+1)-1:0] fail_cnt_q;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         fail_cnt_q <= '0;
         system_reset_req <= 1'b0;
      end else if (!(inhibit_q && crystal_run && !good_q)) begin
         fail_cnt_q <= '0;
         system_reset_req <= 1'b0;
      end else if (fail_cnt_q == ($bits(fail_cnt_q))'(FAIL_CYCLES - 1)) begin
         system_reset_req <= 1'b1;
      end else begin
         fail_cnt_q <= fail_cnt_q + 1'b1;
      end
   end
   // --------------------------------------------------------------
   // RC clock divider, 2 MHz
   // --------------------------------------------------------------
   logic [$clog2(ROCC_RC_DIV+1)-1:0] rc_cnt_q;
   logic rc_clk_q;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rc_cnt_q <= '0;
         rc_clk_q <= 1'b0;
      end else if (rc_cnt_q == ($bits(rc_cnt_q))'(ROCC_RC_DIV - 1)) begin
         rc_cnt_q <= '0;
         rc_clk_q <= !rc_clk_q;
      end else begin
         rc_cnt_q <= rc_cnt_q + 1'b1;
      end
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ext_power_clk <= 1'b0;
      end else begin
         ext_power_clk <= rc_clk_q && (external_power_enable_a || external_power_enable_b);
      end
   end
   // --------------------------------------------------------------
   // source select, switched only with both sources low
   // --------------------------------------------------------------
   logic use_xtal_q;
   logic xtal_d1_q;
   logic rc_d1_q;
   logic src_clk;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         use_xtal_q <= 1'b0;
         xtal_d1_q <= 1'b0;
         rc_d1_q <= 1'b0;
      end else begin
         xtal_d1_q <= xtal_s;
         rc_d1_q <= rc_clk_q;
         // switch on the new source's fall while the old one is low: no runt
         if (use_xtal_q ? (rc_d1_q && !rc_clk_q && !xtal_s)
               : (xtal_d1_q && !xtal_s && !rc_clk_q)) begin
            use_xtal_q <= good_q || inhibit_q;
         end
      end
   end
   assign src_clk = use_xtal_q ? xtal_s : (inhibit_q ? 1'b0 : rc_clk_q);
   rocc_pin_s pin_q;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pin_q <= '0;
      end else begin
         pin_q.out <= out_en_q && src_clk;
         pin_q.oe <= out_en_q && (!drive_q || !src_clk);
      end
   end
   assign clock_output_pin = pin_q.out;
   assign clock_output_pin_oe = pin_q.oe;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         gpio_osc_out <= 1'b0;
      end else begin
         gpio_osc_out <= crystal_run && xtal_s;
      end
   end
   // --------------------------------------------------------------
   // interrupts
   // --------------------------------------------------------------
   logic good_d1_q;
   logic [ROCC_N_IRQ-1:0] ev;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         good_d1_q <= 1'b0;
      end else begin
         good_d1_q <= good_q;
      end
   end
   assign ev[ROCC_IRQ_GOOD] = good_q && !good_d1_q;
   assign ev[ROCC_IRQ_FAIL] = !good_q && good_d1_q;
   assign ev[ROCC_IRQ_RESET] = system_reset_req;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         irq_stat_q <= '0;
      end else begin
         for (int i = 0; i < ROCC_N_IRQ; i++) begin
            if (ev[i]) begin
               irq_stat_q[i] <= 1'b1;
            end else if (wr && addr == ROCC_ADDR_IRQ_STAT && wdata[i]) begin
               irq_stat_q[i] <= 1'b0;
            end
         end
      end
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         irq_mask_q <= ROCC_RST_MASK;
      end else if (wr && addr == ROCC_ADDR_IRQ_MASK) begin
         irq_mask_q <= wdata[ROCC_N_IRQ-1:0];
      end
   end
   assign irq = |(irq_stat_q & ~irq_mask_q);
   // --------------------------------------------------------------
   // read port
   // --------------------------------------------------------------
   logic [15:0] rd_d;
   always_comb begin
      rd_d = 16'h0000;
      case (addr)
         ROCC_ADDR_STATUS: rd_d[ROCC_B_OSC_GOOD] = good_q;
         ROCC_ADDR_CLKCTL1: begin
            rd_d[ROCC_B_OUT_EN] = out_en_q;
            rd_d[ROCC_B_DRIVE] = drive_q;
            rd_d[ROCC_B_ON_SLOT +: 3] = on_slot_q;
            rd_d[ROCC_B_SLP_SLOT +: 3] = slp_slot_q;
         end
         ROCC_ADDR_CLKCTL2: begin
            rd_d[ROCC_B_INHIBIT] = inhibit_q;
            rd_d[ROCC_B_XTAL_EN] = xtal_en_q;
            rd_d[ROCC_B_BKUP] = bkup_q;
         end
         ROCC_ADDR_IRQ_STAT: rd_d[ROCC_N_IRQ-1:0] = irq_stat_q;
         ROCC_ADDR_IRQ_MASK: rd_d[ROCC_N_IRQ-1:0] = irq_mask_q;
         default: rd_d = 16'h0000;
      endcase
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdata <= 16'h0000;
      end else if (rd) begin
         rdata <= rd_d;
      end else begin
         rdata <= 16'h0000;
      end
   end
   // --------------------------------------------------------------
   // assertions
   // --------------------------------------------------------------
   a_off_forces_low: assert property (@(posedge clk) disable iff (!nrst)
      pstate == ROCC_PS_OFF |=> !out_en_q ##1 !clock_output_pin)
      else $error("clock output active in OFF");
   a_enable_locked: assert property (@(posedge clk) disable iff (!nrst)
      wr_ctl1 && !unlocked_q && !on_hit && !slp_hit
      && (pstate == ROCC_PS_ON || pstate == ROCC_PS_SLEEP) |=> $stable(out_en_q))
      else $error("locked write changed output enable");
   a_cfg_only_enable: assert property (@(posedge clk) disable iff (!nrst)
      !external_config_load |=> $stable(xtal_en_q))
      else $error("crystal enable changed without config load");
   a_backup_stop: assert property (@(posedge clk) disable iff (!nrst)
      pstate == ROCC_PS_BACKUP && !bkup_q |-> !crystal_run)
      else $error("crystal running in backup without retain");
   a_good_needs_run: assert property (@(posedge clk) disable iff (!nrst)
      !crystal_run |=> !good_q)
      else $error("good status while crystal stopped");
   a_on_held: assert property (@(posedge clk) disable iff (!nrst)
      inhibit_q && !good_q |-> !on_grant)
      else $error("ON granted before crystal verified");
   a_on_slot_hit: assert property (@(posedge clk) disable iff (!nrst)
      on_hit && pstate == ROCC_PS_ON |=> out_en_q)
      else $error("on slot did not enable output");
   a_sleep_slot_hit: assert property (@(posedge clk) disable iff (!nrst)
      slp_hit && !on_hit |=> !out_en_q)
      else $error("sleep slot did not disable output");
   a_opendrain_high: assert property (@(posedge clk) disable iff (!nrst)
      drive_q && out_en_q && src_clk |=> !clock_output_pin_oe ##0 clock_output_pin)
      else $error("open-drain drove high");
   a_epe_gate: assert property (@(posedge clk) disable iff (!nrst)
      !external_power_enable_a && !external_power_enable_b |=> !ext_power_clk)
      else $error("power clock without enable");
endmodule
`default_nettype wire

// ===== rocc_pkg.sv
/*
 oscillator and clock output control: register offsets, fields, constants, carriers.
 assumes a 16-bit register port and a 125 MHz system clock.
*/
package rocc_pkg;
   // --------------------------------------------------------------
   // register map
   // --------------------------------------------------------------
   localparam logic [15:0] ROCC_ADDR_STATUS = 16'h400d;
   localparam logic [15:0] ROCC_ADDR_CLKCTL1 = 16'h4090;
   localparam logic [15:0] ROCC_ADDR_CLKCTL2 = 16'h4091;
   localparam logic [15:0] ROCC_ADDR_KEY = 16'h4008;
   localparam logic [15:0] ROCC_ADDR_IRQ_STAT = 16'h4100;
   localparam logic [15:0] ROCC_ADDR_IRQ_MASK = 16'h4101;
   localparam logic [15:0] ROCC_KEY_UNLOCK = 16'h9716;
   localparam logic [15:0] ROCC_KEY_LOCK = 16'h0000;
   // --------------------------------------------------------------
   // field positions
   // --------------------------------------------------------------
   localparam int ROCC_B_OSC_GOOD = 7;
   localparam int ROCC_B_OUT_EN = 15;
   localparam int ROCC_B_DRIVE = 13;
   localparam int ROCC_B_ON_SLOT = 8;
   localparam int ROCC_B_SLP_SLOT = 4;
   localparam int ROCC_B_INHIBIT = 15;
   localparam int ROCC_B_XTAL_EN = 13;
   localparam int ROCC_B_BKUP = 12;
   localparam int ROCC_N_IRQ = 3;
   localparam int ROCC_IRQ_GOOD = 0;
   localparam int ROCC_IRQ_FAIL = 1;
   localparam int ROCC_IRQ_RESET = 2;
   localparam logic [2:0] ROCC_SLOT_MIN = 3'h1;
   localparam logic [2:0] ROCC_SLOT_MAX = 3'h5;
   localparam logic [2:0] ROCC_SLP_BASE = 3'h6;
   localparam logic ROCC_RST_INHIBIT = 1'b0;
   localparam logic ROCC_RST_BKUP = 1'b1;
   localparam logic [ROCC_N_IRQ-1:0] ROCC_RST_MASK = 3'h7;
   // --------------------------------------------------------------
   // timing
   // --------------------------------------------------------------
   localparam longint ROCC_CLK_HZ = 125000000;
   localparam longint ROCC_FAIL_TIMEOUT_S = 32;
   localparam longint ROCC_FAIL_CYCLES = ROCC_FAIL_TIMEOUT_S * ROCC_CLK_HZ;
   localparam longint ROCC_RC_HZ = 2000000;
   localparam longint ROCC_RC_DIV = ROCC_CLK_HZ / ROCC_RC_HZ / 2;
   // --------------------------------------------------------------
   // types
   // --------------------------------------------------------------
   typedef enum logic [1:0] {
      ROCC_PS_OFF,
      ROCC_PS_ON,
      ROCC_PS_SLEEP,
      ROCC_PS_BACKUP
   } rocc_pstate_e;
   typedef struct packed {
      logic [2:0] slot;
      logic on_seq;
      logic sleep_seq;
   } rocc_seq_s;
   typedef struct packed {
      logic out;
      logic oe;
   } rocc_pin_s;
endpackage

// ===== rocc_sync.sv
/*
 three-stage synchroniser; the change is taken once stages two and three agree.
 assumes a single clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module rocc_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] s1_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         dout <= '0;
      end else begin
         s1_q <= din;
         s2_q <= s1_q;
         s3_q <= s2_q;
         for (int i = 0; i < WIDTH; i++) begin
            if (s2_q[i] == s3_q[i]) begin
               dout[i] <= s3_q[i];
            end
         end
      end
   end
endmodule
`default_nettype wire

// ===== rocc_seq_model.sv
/*
 power sequencer model: power state, on request and one timeslot strobe.
 assumes the control block answers on_grant combinationally on clk.
*/
`timescale 1ns/1ps
`default_nettype none
module rocc_seq_model
   import rocc_pkg::*;
(
   input wire logic clk,
   input wire logic on_grant,
   output rocc_pstate_e pstate,
   output rocc_seq_s seq,
   output logic on_request
);
   // ------------------------------------------
   // transitions
   // ------------------------------------------
   initial begin
      pstate = ROCC_PS_OFF;
      seq = '0;
      on_request = 1'h0;
   end
   task automatic set_state(input rocc_pstate_e s);
      @(posedge clk);
      pstate <= s;
   endtask
   // one strobe for the chosen slot
   task automatic strobe(input int k, input logic on_seq);
      @(posedge clk);
      seq <= {3'(k), on_seq, ~on_seq};
      @(posedge clk);
      seq <= '0;
   endtask
   // request held until granted or given up
   task automatic run_on(output logic granted, input int k);
      granted = 1'h0;
      @(posedge clk);
      on_request <= 1'h1;
      for (int i = 0; i < 20 && !granted; i++) begin
         @(posedge clk);
         #1 granted = (on_grant === 1'h1);
      end
      @(posedge clk);
      on_request <= 1'h0;
      if (granted) begin
         pstate <= ROCC_PS_ON;
         strobe(k, 1'h1);
      end
   endtask
   task automatic run_sleep(input int k);
      @(posedge clk);
      pstate <= ROCC_PS_SLEEP;
      strobe(k, 1'h0);
   endtask
endmodule
`default_nettype wire

// ===== rtc_oscillator_clock_output_pin_control_bench.sv
/*
 self-checking bench for the oscillator and clock output control block.
 assumes the sequencer model beside it and a 125 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module rtc_oscillator_clock_output_pin_control_bench
   import rocc_pkg::*;
;
   logic clk = 1'h0, nrst = 1'h0, wr = 1'h0, rd = 1'h0, ld = 1'h0, c_en = 1'h0;
   logic c_bk = 1'h1, c_inh = 1'h0, xv = 1'h0, xf = 1'h0, epa = 1'h0, epb = 1'h0;
   logic [15:0] addr = 16'h0, wdata = 16'h0, rdata, rv;
   logic on_request, on_grant, crystal_run, pin, pin_oe, gpio, epc, rst_req, irq, gr;
   logic [4:0] osc_cnt = 5'h0;
   wire logic osc_pin = osc_cnt[4] & crystal_run;
   rocc_pstate_e pstate;
   rocc_seq_s seq;
   int bad_count = 0, check_count = 0, od_bad, oe_off, tog, rmin, n;
   always #4 clk = ~clk;
   always @(posedge clk) osc_cnt <= osc_cnt + 5'h1;
   rocc_ctrl #(.FAIL_CYCLES(100)) u_dut (.clk(clk), .nrst(nrst), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .external_config_load(ld),
      .cfg_crystal_enable(c_en), .cfg_crystal_backup_retain(c_bk),
      .cfg_startup_inhibit(c_inh), .pstate(pstate), .seq(seq),
      .on_request(on_request), .on_grant(on_grant), .oscillator_input_pin(osc_pin),
      .xtal_verified(xv), .xtal_failed(xf), .crystal_run(crystal_run),
      .clock_output_pin(pin), .clock_output_pin_oe(pin_oe), .gpio_osc_out(gpio),
      .external_power_enable_a(epa), .external_power_enable_b(epb),
      .ext_power_clk(epc), .system_reset_req(rst_req), .irq(irq));
   rocc_seq_model u_seq (.clk(clk), .on_grant(on_grant), .pstate(pstate), .seq(seq),
      .on_request(on_request));
   // ------------------------------------------
   // shared tasks
   // ------------------------------------------
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      check_count++;
      if (g !== e) begin
         $display("ERROR %s expected %h seen %h", nm, e, g);
         bad_count++;
      end
   endtask
   task automatic wreg(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk);
      wr <= 1'h1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'h0;
   endtask
   task automatic rreg(input logic [15:0] a);
      @(posedge clk);
      rd <= 1'h1;
      addr <= a;
      @(posedge clk);
      rd <= 1'h0;
      #1 rv = rdata;
   endtask
   task automatic kwr(input logic [15:0] a, input logic [15:0] d);
      wreg(ROCC_ADDR_KEY, ROCC_KEY_UNLOCK);
      wreg(a, d);
      wreg(ROCC_ADDR_KEY, ROCC_KEY_LOCK);
   endtask
   function automatic logic pick(input int s);
      return s == 0 ? pin : (s == 1 ? gpio : epc);
   endfunction
   task automatic watch(input int s, input int cyc);
      logic prev;
      int run;
      prev = pick(s);
      run = 0;
      tog = 0;
      rmin = 1000;
      od_bad = 0;
      oe_off = 0;
      repeat (cyc) begin
         @(posedge clk);
         #1;
         od_bad += int'(pin_oe === 1'h1 && pin === 1'h1);
         oe_off += int'(pin_oe !== 1'h1);
         run++;
         if (pick(s) !== prev) begin
            tog++;
            if (tog > 1 && run < rmin) rmin = run;
            run = 0;
         end
         prev = pick(s);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // ------------------------------------------
   // scenarios
   // ------------------------------------------
   task automatic t_reset();
      rreg(ROCC_ADDR_STATUS);
      chk("status", 16'h0, rv & 16'h0080);
      rreg(ROCC_ADDR_CLKCTL1);
      chk("clkctl1", 16'h0, rv & 16'ha770);
      rreg(ROCC_ADDR_CLKCTL2);
      chk("clkctl2", 16'h1000, rv & 16'hb000);
      chk("irq", 16'h0, {15'h0, irq});
      $display("test reset done");
   endtask
   task automatic t_cfg();
      @(posedge clk);
      c_en <= 1'h1;
      ld <= 1'h1;
      @(posedge clk);
      ld <= 1'h0;
      repeat (3) @(posedge clk);
      #1 chk("run_off", 16'h1, {15'h0, crystal_run});
      wreg(ROCC_ADDR_CLKCTL2, 16'h1000);
      rreg(ROCC_ADDR_CLKCTL2);
      chk("xtal_en_ro", 16'h3000, rv & 16'h3000);
      u_seq.set_state(ROCC_PS_BACKUP);
      repeat (2) @(posedge clk);
      #1 chk("run_bk1", 16'h1, {15'h0, crystal_run});
      wreg(ROCC_ADDR_CLKCTL2, 16'h0000);
      repeat (2) @(posedge clk);
      #1 chk("run_bk0", 16'h0, {15'h0, crystal_run});
      wreg(ROCC_ADDR_CLKCTL2, 16'h1000);
      u_seq.set_state(ROCC_PS_OFF);
      watch(1, 100);
      chk("gpio_off", 16'h1, 16'(tog >= 4));
      $display("test config done");
   endtask
   task automatic t_key();
      u_seq.set_state(ROCC_PS_ON);
      wreg(ROCC_ADDR_CLKCTL1, 16'h8000);
      rreg(ROCC_ADDR_CLKCTL1);
      chk("en_locked", 16'h0, rv & 16'h8000);
      kwr(ROCC_ADDR_CLKCTL1, 16'h8000);
      rreg(ROCC_ADDR_CLKCTL1);
      chk("en_unlocked", 16'h8000, rv & 16'h8000);
      wreg(ROCC_ADDR_CLKCTL1, 16'h0000);
      rreg(ROCC_ADDR_CLKCTL1);
      chk("en_relocked", 16'h8000, rv & 16'h8000);
      u_seq.set_state(ROCC_PS_OFF);
      repeat (2) @(posedge clk);
      watch(0, 20);
      chk("oe_in_off", 16'd20, 16'(oe_off));
      rreg(16'h4a5a);
      chk("unmapped", 16'h0, rv);
      $display("test key done");
   endtask
   task automatic t_slots();
      for (int c = 0; c < 8; c++) begin
         for (int k = 1; k <= 5; k++) begin
            kwr(ROCC_ADDR_CLKCTL1, 16'(c) << 8);
            u_seq.set_state(ROCC_PS_OFF);
            u_seq.run_on(gr, k);
            rreg(ROCC_ADDR_CLKCTL1);
            chk("on_slot", (c == k) ? 16'h8000 : 16'h0, rv & 16'h8000);
            kwr(ROCC_ADDR_CLKCTL1, 16'h8000 | (16'(c) << 4));
            u_seq.set_state(ROCC_PS_ON);
            u_seq.run_sleep(k);
            rreg(ROCC_ADDR_CLKCTL1);
            chk("slp_slot", (c + k == 6) ? 16'h0 : 16'h8000, rv & 16'h8000);
         end
      end
      $display("test slots done");
   endtask
   task automatic t_drive();
      u_seq.set_state(ROCC_PS_ON);
      kwr(ROCC_ADDR_CLKCTL1, 16'h0000);
      watch(0, 20);
      chk("oe_host_off", 16'd20, 16'(oe_off));
      kwr(ROCC_ADDR_CLKCTL1, 16'h8000);
      watch(0, 200);
      chk("pushpull_oe", 16'h0, 16'(oe_off));
      chk("rc_toggle", 16'h1, 16'(tog >= 4));
      kwr(ROCC_ADDR_CLKCTL1, 16'ha000);
      watch(0, 200);
      chk("od_high", 16'h0, 16'(od_bad));
      chk("od_oe", 16'h1, 16'(oe_off > 20 && oe_off < 180));
      kwr(ROCC_ADDR_CLKCTL1, 16'h8000);
      $display("test drive done");
   endtask
   task automatic t_good();
      wreg(ROCC_ADDR_IRQ_MASK, 16'h0002);
      @(posedge clk);
      xv <= 1'h1;
      watch(0, 300);
      chk("no_runt", 16'h1, 16'(rmin >= 8));
      n = 0;
      do begin
         rreg(ROCC_ADDR_STATUS);
         n++;
      end while (rv[7] !== 1'h1 && n < 30);
      chk("good_set", 16'h0080, rv & 16'h0080);
      chk("irq_good", 16'h1, {15'h0, irq});
      rreg(ROCC_ADDR_IRQ_STAT);
      chk("stat_rise", 16'h0001, rv & 16'h0007);
      wreg(ROCC_ADDR_IRQ_STAT, 16'h0001);
      #1 chk("irq_clear", 16'h0, {15'h0, irq});
      @(posedge clk);
      xv <= 1'h0;
      repeat (8) @(posedge clk);
      rreg(ROCC_ADDR_STATUS);
      chk("good_stop", 16'h0, rv & 16'h0080);
      rreg(ROCC_ADDR_IRQ_STAT);
      chk("stat_fall", 16'h0002, rv & 16'h0007);
      chk("irq_masked", 16'h0, {15'h0, irq});
      wreg(ROCC_ADDR_IRQ_STAT, 16'h0007);
      $display("test good done");
   endtask
   task automatic t_epc();
      for (int m = 0; m < 3; m++) begin
         @(posedge clk);
         epa <= (m == 1);
         epb <= (m == 2);
         repeat (8) @(posedge clk);
         watch(2, 200);
         chk("ext_clk", 16'(m > 0), 16'(tog >= 2));
      end
      $display("test power clock done");
   endtask
   task automatic t_inhibit();
      wreg(ROCC_ADDR_CLKCTL2, 16'h9000);
      @(posedge clk);
      xf <= 1'h1;
      n = 1;
      while (rst_req !== 1'h1 && n < 400) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk("reset_delay", 16'h1, 16'(n >= 98 && n <= 106));
      u_seq.set_state(ROCC_PS_OFF);
      u_seq.run_on(gr, 1);
      chk("on_held", 16'h0, {15'h0, gr});
      @(posedge clk);
      xf <= 1'h0;
      xv <= 1'h1;
      repeat (10) @(posedge clk);
      u_seq.run_on(gr, 1);
      chk("on_granted", 16'h1, {15'h0, gr});
      @(posedge clk);
      nrst <= 1'h0;
      repeat (3) @(posedge clk);
      #1 chk("reset_req_clr", 16'h0, {15'h0, rst_req});
      @(posedge clk);
      nrst <= 1'h1;
      rreg(ROCC_ADDR_CLKCTL2);
      chk("inhibit_def", 16'h0, rv & 16'h8000);
      $display("test inhibit done");
   endtask
   initial begin
      repeat (12) @(posedge clk);
      nrst <= 1'h1;
      t_reset();
      t_cfg();
      t_key();
      t_slots();
      t_drive();
      t_good();
      t_epc();
      t_inhibit();
      give_verdict();
   end
endmodule
`default_nettype wire
